// file: exec_map.svh
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// ********************
// Status bit positions
// ********************
`define FLAG_C         3'd0
`define FLAG_Z         3'd1
`define FLAG_N         3'd2
`define FLAG_V         3'd3
`define FLAG_S         3'd4
`define FLAG_H         3'd5

// ********************
// Cycle counts
// ********************
`define LAT_ALU        3'd1
`define LAT_WORD       3'd2
`define LAT_MUL        3'd2
`define LAT_PTR_JUMP   3'd2
`define LAT_PTR_CALL   3'd3
`define LAT_ABS_JUMP   3'd3
`define LAT_ABS_CALL   3'd4
`define LAT_NO_SKIP    3'd1
`define LAT_SKIP_SHORT 3'd2
`define LAT_SKIP_LONG  3'd3

// ********************
// Program counter steps
// ********************
`define SKIP_SHORT_STEP 16'h0002
`define SKIP_LONG_STEP  16'h0003
`define PTR_CALL_RET    16'h0001
`define ABS_CALL_RET    16'h0002

// ********************
// Values
// ********************
`define BYTE_ALL_ONES  8'hFF
`define RESET_BYTE     8'h00
`define RESET_WORD     16'h0000

`endif

// file: exec_pkg.sv
package exec_pkg;

	// ********************
	// Operation codes
	// ********************
	typedef enum logic [4:0] {
		nop_op,
		add_op,
		add_carry_op,
		word_add_immediate_op,
		sub_op,
		sub_immediate_op,
		sub_with_carry_op,
		sub_carry_immediate_op,
		word_sub_immediate_op,
		and_op,
		and_immediate_op,
		or_op,
		or_immediate_op,
		set_bits_op,
		clear_bits_op,
		test_value_op,
		multiply_op,
		signed_multiply_op,
		mixed_sign_multiply_op,
		fractional_multiply_op,
		fractional_signed_multiply_op,
		fractional_mixed_multiply_op,
		pointer_jump_op,
		pointer_call_op,
		absolute_jump_op,
		absolute_call_op,
		compare_skip_equal_op,
		compare_immediate_op,
		skip_reg_bit_low_op,
		skip_io_bit_low_op
	} op_t;

	// ********************
	// Sequencer states
	// ********************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} state_t;

endpackage

// file: add_sub8.sv
`timescale 1ns/1ns
module add_sub8
(
	// Operands
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       cin,
	input  wire logic       sub,
	// Result and flags
	output logic      [7:0] res,
	output logic            c,
	output logic            h,
	output logic            v
);
	logic [8:0] full;
	logic [4:0] nib;

	always_comb
	begin
		if (sub)
		begin
			full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
			nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
		end
		else
		begin
			full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		end
		res = full[7:0];
		c   = full[8];
		h   = nib[4];
		// Sign change only possible when operand signs agree (add) or differ (sub)
		v   = ((a[7] ^ b[7]) == sub) && (full[7] != a[7]);
	end
endmodule

// file: mul8.sv
`timescale 1ns/1ns
module mul8
(
	// Operands and mode
	input  wire logic [7:0]  a,
	input  wire logic [7:0]  b,
	input  wire logic        a_signed,
	input  wire logic        b_signed,
	input  wire logic        frac,
	// Product and flags
	output logic      [15:0] prod,
	output logic             c,
	output logic             z
);
	logic signed [8:0]  ax;
	logic signed [8:0]  bx;
	logic signed [17:0] p;

	always_comb
	begin
		ax   = {a_signed & a[7], a};
		bx   = {b_signed & b[7], b};
		p    = ax * bx;
		// Carry is the top bit before the fractional shift drops it
		c    = p[15];
		prod = frac ? {p[14:0], 1'b0} : p[15:0];
		z    = (prod == 16'h0000);
	end
endmodule

// file: mcu_arith_branch_exec.sv
`timescale 1ns/1ns
`include "exec_map.svh"
module mcu_arith_branch_exec
	import exec_pkg::*;
#(
	parameter bit ABS_BRANCH_EN = 1'b1
)
(
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST,
	// Request from decoder
	input  wire logic        START,
	input  wire op_t         OP,
	input  wire logic [7:0]  DST_VAL,
	input  wire logic [7:0]  DST_HI_VAL,
	input  wire logic [7:0]  SRC_VAL,
	input  wire logic [7:0]  IMM_VAL,
	input  wire logic [2:0]  BIT_SEL,
	input  wire logic [7:0]  IO_VAL,
	input  wire logic [7:0]  SREG_IN,
	input  wire logic [15:0] PC_IN,
	input  wire logic [15:0] Z_PTR,
	input  wire logic [15:0] TARGET,
	input  wire logic        NEXT_LONG,
	// Status
	output logic             BUSY,
	output logic             DONE,
	// Register file write back
	output logic             REG_WE,
	output logic             PAIR_WE,
	output logic             PROD_WE,
	output logic      [7:0]  RES_LO,
	output logic      [7:0]  RES_HI,
	output logic             SREG_WE,
	output logic      [7:0]  SREG_OUT,
	// Program flow
	output logic             PC_WE,
	output logic      [15:0] PC_OUT,
	output logic             PUSH_WE,
	output logic      [15:0] PUSH_ADDR
);

	// ********************
	// Functions
	// ********************
	function automatic logic skip_test(op_t op, logic [7:0] d, logic [7:0] s,
		logic [2:0] sel, logic [7:0] io);
		logic r;
		r = 1'b0;
		case (op)
			compare_skip_equal_op: r = (d == s);
			skip_reg_bit_low_op:   r = !s[sel];
			skip_io_bit_low_op:    r = !io[sel];
			default:               r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic [2:0] lat_of(op_t op, logic skip, logic lng);
		logic [2:0] l;
		l = `LAT_ALU;
		case (op)
			word_add_immediate_op, word_sub_immediate_op: l = `LAT_WORD;
			multiply_op, signed_multiply_op, mixed_sign_multiply_op,
			fractional_multiply_op, fractional_signed_multiply_op,
			fractional_mixed_multiply_op:                 l = `LAT_MUL;
			pointer_jump_op:                              l = `LAT_PTR_JUMP;
			pointer_call_op:                              l = `LAT_PTR_CALL;
			absolute_jump_op:  l = ABS_BRANCH_EN ? `LAT_ABS_JUMP : `LAT_ALU;
			absolute_call_op:  l = ABS_BRANCH_EN ? `LAT_ABS_CALL : `LAT_ALU;
			compare_skip_equal_op, skip_reg_bit_low_op, skip_io_bit_low_op:
				l = !skip ? `LAT_NO_SKIP : (lng ? `LAT_SKIP_LONG : `LAT_SKIP_SHORT);
			default:                                      l = `LAT_ALU;
		endcase
		return l;
	endfunction

	function automatic logic [7:0] logic_flags(logic [7:0] s, logic [7:0] r);
		logic [7:0] f;
		f = s;
		f[`FLAG_Z] = (r == 8'h00);
		f[`FLAG_N] = r[7];
		f[`FLAG_V] = 1'b0;
		return f;
	endfunction

	// ********************
	// Operand capture
	// ********************
	state_t      state_r;
	logic [2:0]  cnt_r;
	op_t         op_r;
	logic [7:0]  dst_r;
	logic [7:0]  dsth_r;
	logic [7:0]  src_r;
	logic [7:0]  imm_r;
	logic [7:0]  sreg_r;
	logic [15:0] pc_r;
	logic [15:0] zp_r;
	logic [15:0] tgt_r;
	logic        skip_r;
	logic        long_r;
	logic        take;
	logic        commit;

	// Holding off while DONE is up keeps operands from reading stale registers
	assign take   = START && (state_r == ST_IDLE) && !DONE;
	assign commit = (state_r == ST_EXEC) && (cnt_r == 3'd1);

	always_ff @(posedge MCLK)
	begin
		if (take)
		begin
			op_r   <= OP;
			dst_r  <= DST_VAL;
			dsth_r <= DST_HI_VAL;
			src_r  <= SRC_VAL;
			imm_r  <= IMM_VAL;
			sreg_r <= SREG_IN;
			pc_r   <= PC_IN;
			zp_r   <= Z_PTR;
			tgt_r  <= TARGET;
			skip_r <= skip_test(OP, DST_VAL, SRC_VAL, BIT_SEL, IO_VAL);
			long_r <= NEXT_LONG;
		end
	end

	// ********************
	// Sequencer
	// ********************
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			state_r <= ST_IDLE;
			cnt_r   <= 3'd0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					if (take)
					begin
						state_r <= ST_EXEC;
						cnt_r   <= lat_of(OP, skip_test(OP, DST_VAL, SRC_VAL, BIT_SEL, IO_VAL),
							NEXT_LONG);
					end
				end
				ST_EXEC:
				begin
					cnt_r <= cnt_r - 3'd1;
					if (commit)
						state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ********************
	// Datapath
	// ********************
	logic [7:0]  b_sel;
	logic        cin_sel;
	logic        sub_sel;
	logic [7:0]  alu_res;
	logic        alu_c;
	logic        alu_h;
	logic        alu_v;
	logic [15:0] prod;
	logic        mul_c;
	logic        mul_z;
	logic        a_sgn;
	logic        b_sgn;
	logic        frac;
	logic [15:0] word_res;
	logic [15:0] word_in;

	always_comb
	begin
		b_sel   = src_r;
		cin_sel = 1'b0;
		sub_sel = 1'b0;
		case (op_r)
			add_carry_op:
				cin_sel = sreg_r[`FLAG_C];
			sub_op:
				sub_sel = 1'b1;
			sub_immediate_op, compare_immediate_op:
			begin
				b_sel   = imm_r;
				sub_sel = 1'b1;
			end
			sub_with_carry_op:
			begin
				sub_sel = 1'b1;
				cin_sel = sreg_r[`FLAG_C];
			end
			sub_carry_immediate_op:
			begin
				b_sel   = imm_r;
				sub_sel = 1'b1;
				cin_sel = sreg_r[`FLAG_C];
			end
			default:
				b_sel = src_r;
		endcase
	end

	add_sub8 u_alu (
		.a   (dst_r),
		.b   (b_sel),
		.cin (cin_sel),
		.sub (sub_sel),
		.res (alu_res),
		.c   (alu_c),
		.h   (alu_h),
		.v   (alu_v)
	);

	assign a_sgn = (op_r == signed_multiply_op) || (op_r == mixed_sign_multiply_op) ||
		(op_r == fractional_signed_multiply_op) || (op_r == fractional_mixed_multiply_op);
	assign b_sgn = (op_r == signed_multiply_op) || (op_r == fractional_signed_multiply_op);
	assign frac  = (op_r == fractional_multiply_op) ||
		(op_r == fractional_signed_multiply_op) || (op_r == fractional_mixed_multiply_op);

	mul8 u_mul (
		.a        (dst_r),
		.b        (src_r),
		.a_signed (a_sgn),
		.b_signed (b_sgn),
		.frac     (frac),
		.prod     (prod),
		.c        (mul_c),
		.z        (mul_z)
	);

	// Word constant is six bits wide; upper immediate bits are ignored
	assign word_in  = {dsth_r, dst_r};
	assign word_res = (op_r == word_sub_immediate_op) ? word_in - {10'h000, imm_r[5:0]}
		: word_in + {10'h000, imm_r[5:0]};

	// ********************
	// Completion values
	// ********************
	logic [7:0]  res_lo_nxt;
	logic [7:0]  res_hi_nxt;
	logic [7:0]  sreg_nxt;
	logic        reg_we_nxt;
	logic        pair_we_nxt;
	logic        prod_we_nxt;
	logic        sreg_we_nxt;
	logic        pc_we_nxt;
	logic [15:0] pc_nxt;
	logic        push_we_nxt;
	logic [15:0] push_nxt;

	always_comb
	begin
		res_lo_nxt  = dst_r;
		res_hi_nxt  = dsth_r;
		sreg_nxt    = sreg_r;
		reg_we_nxt  = 1'b0;
		pair_we_nxt = 1'b0;
		prod_we_nxt = 1'b0;
		sreg_we_nxt = 1'b0;
		pc_we_nxt   = 1'b0;
		pc_nxt      = pc_r;
		push_we_nxt = 1'b0;
		push_nxt    = pc_r;
		case (op_r)
			add_op, add_carry_op, sub_op, sub_immediate_op, sub_with_carry_op,
			sub_carry_immediate_op, compare_immediate_op:
			begin
				res_lo_nxt         = alu_res;
				reg_we_nxt         = (op_r != compare_immediate_op);
				sreg_we_nxt        = 1'b1;
				sreg_nxt[`FLAG_Z]  = (alu_res == 8'h00);
				sreg_nxt[`FLAG_C]  = alu_c;
				sreg_nxt[`FLAG_N]  = alu_res[7];
				sreg_nxt[`FLAG_V]  = alu_v;
				sreg_nxt[`FLAG_H]  = alu_h;
			end
			word_add_immediate_op, word_sub_immediate_op:
			begin
				{res_hi_nxt, res_lo_nxt} = word_res;
				pair_we_nxt        = 1'b1;
				sreg_we_nxt        = 1'b1;
				sreg_nxt[`FLAG_Z]  = (word_res == 16'h0000);
				sreg_nxt[`FLAG_N]  = word_res[15];
				if (op_r == word_add_immediate_op)
				begin
					sreg_nxt[`FLAG_V] = !dsth_r[7] && word_res[15];
					sreg_nxt[`FLAG_C] = dsth_r[7] && !word_res[15];
				end
				else
				begin
					sreg_nxt[`FLAG_V] = dsth_r[7] && !word_res[15];
					sreg_nxt[`FLAG_C] = !dsth_r[7] && word_res[15];
				end
				sreg_nxt[`FLAG_S]  = sreg_nxt[`FLAG_N] ^ sreg_nxt[`FLAG_V];
			end
			and_op, and_immediate_op, or_op, or_immediate_op, set_bits_op,
			clear_bits_op, test_value_op:
			begin
				case (op_r)
					and_op:           res_lo_nxt = dst_r & src_r;
					and_immediate_op: res_lo_nxt = dst_r & imm_r;
					or_op:            res_lo_nxt = dst_r | src_r;
					clear_bits_op:    res_lo_nxt = dst_r & (`BYTE_ALL_ONES - imm_r);
					test_value_op:    res_lo_nxt = dst_r & dst_r;
					default:          res_lo_nxt = dst_r | imm_r;
				endcase
				reg_we_nxt  = 1'b1;
				sreg_we_nxt = 1'b1;
				sreg_nxt    = logic_flags(sreg_r, res_lo_nxt);
			end
			multiply_op, signed_multiply_op, mixed_sign_multiply_op,
			fractional_multiply_op, fractional_signed_multiply_op,
			fractional_mixed_multiply_op:
			begin
				{res_hi_nxt, res_lo_nxt} = prod;
				prod_we_nxt       = 1'b1;
				sreg_we_nxt       = 1'b1;
				sreg_nxt[`FLAG_C] = mul_c;
				sreg_nxt[`FLAG_Z] = mul_z;
			end
			pointer_jump_op, pointer_call_op:
			begin
				pc_we_nxt   = 1'b1;
				pc_nxt      = zp_r;
				push_we_nxt = (op_r == pointer_call_op);
				push_nxt    = pc_r + `PTR_CALL_RET;
			end
			absolute_jump_op, absolute_call_op:
			begin
				// Smaller parts treat these as a one-cycle no-op
				pc_we_nxt   = ABS_BRANCH_EN;
				pc_nxt      = tgt_r;
				push_we_nxt = ABS_BRANCH_EN && (op_r == absolute_call_op);
				push_nxt    = pc_r + `ABS_CALL_RET;
			end
			compare_skip_equal_op, skip_reg_bit_low_op, skip_io_bit_low_op:
			begin
				pc_we_nxt = skip_r;
				pc_nxt    = pc_r + (long_r ? `SKIP_LONG_STEP : `SKIP_SHORT_STEP);
			end
			default:
				pc_nxt = pc_r;
		endcase
	end

	// ********************
	// Outputs
	// ********************
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			BUSY      <= 1'b0;
			DONE      <= 1'b0;
			REG_WE    <= 1'b0;
			PAIR_WE   <= 1'b0;
			PROD_WE   <= 1'b0;
			RES_LO    <= `RESET_BYTE;
			RES_HI    <= `RESET_BYTE;
			SREG_WE   <= 1'b0;
			SREG_OUT  <= `RESET_BYTE;
			PC_WE     <= 1'b0;
			PC_OUT    <= `RESET_WORD;
			PUSH_WE   <= 1'b0;
			PUSH_ADDR <= `RESET_WORD;
		end
		else
		begin
			BUSY    <= take || ((state_r == ST_EXEC) && !commit);
			DONE    <= commit;
			REG_WE  <= commit && reg_we_nxt;
			PAIR_WE <= commit && pair_we_nxt;
			PROD_WE <= commit && prod_we_nxt;
			SREG_WE <= commit && sreg_we_nxt;
			PC_WE   <= commit && pc_we_nxt;
			PUSH_WE <= commit && push_we_nxt;
			if (commit)
			begin
				RES_LO    <= res_lo_nxt;
				RES_HI    <= res_hi_nxt;
				SREG_OUT  <= sreg_nxt;
				PC_OUT    <= pc_nxt;
				PUSH_ADDR <= push_nxt;
			end
		end
	end

	// ********************
	// Checks
	// ********************
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	a_add_one_cycle: assert property (take && (OP == add_op || OP == add_carry_op)
		|=> BUSY ##1 (DONE && REG_WE && SREG_WE))
		else $error("add did not finish in one cycle");
	a_add_carry_sum: assert property (DONE && op_r == add_carry_op
		|-> RES_LO == 8'(dst_r + src_r + {7'h00, sreg_r[`FLAG_C]}))
		else $error("add with carry sum wrong");
	a_word_two_cycles: assert property (take && OP == word_add_immediate_op
		|=> BUSY[*2] ##1 (DONE && PAIR_WE && !REG_WE))
		else $error("word add timing wrong");
	a_word_sub_value: assert property (DONE && op_r == word_sub_immediate_op
		|-> {RES_HI, RES_LO} == 16'({dsth_r, dst_r} - {10'h000, imm_r[5:0]}))
		else $error("word subtract value wrong");
	a_sub_immediate_op_diff: assert property (DONE && op_r == sub_immediate_op
		|-> RES_LO == 8'(dst_r - imm_r) && SREG_OUT[`FLAG_C] == (imm_r > dst_r))
		else $error("subtract immediate wrong");
	a_sbc_value: assert property (DONE && op_r == sub_with_carry_op
		|-> RES_LO == 8'(dst_r - src_r - {7'h00, sreg_r[`FLAG_C]}))
		else $error("subtract with carry wrong");
	a_sub_carry_immediate_op_value: assert property (DONE && op_r == sub_carry_immediate_op
		|-> RES_LO == 8'(dst_r - imm_r - {7'h00, sreg_r[`FLAG_C]}))
		else $error("immediate subtract with carry wrong");
	a_and_keeps_carry: assert property (DONE && (op_r inside {and_op, and_immediate_op})
		|-> !SREG_OUT[`FLAG_V] && SREG_OUT[`FLAG_C] == sreg_r[`FLAG_C])
		else $error("and touched carry or overflow");
	a_or_value: assert property (DONE && op_r == or_op |-> RES_LO == (dst_r | src_r))
		else $error("or value wrong");
	a_set_bits: assert property (DONE && op_r == set_bits_op |-> RES_LO == (dst_r | imm_r))
		else $error("set bits wrong");
	a_clear_bits: assert property (DONE && op_r == clear_bits_op
		|-> RES_LO == (dst_r & ~imm_r))
		else $error("clear bits wrong");
	a_test_zero: assert property (DONE && op_r == test_value_op
		|-> SREG_OUT[`FLAG_Z] == (dst_r == 8'h00) && SREG_OUT[`FLAG_N] == dst_r[7])
		else $error("test flags wrong");
	a_mul_two_cycles: assert property (take && OP == multiply_op
		|=> BUSY ##1 BUSY ##1 (DONE && PROD_WE && {RES_HI, RES_LO} == 16'(dst_r) * 16'(src_r)))
		else $error("multiply wrong");
	a_fmul_shift: assert property (DONE && op_r == fractional_multiply_op
		|-> {RES_HI, RES_LO} == 16'({16'(dst_r) * 16'(src_r), 1'b0}))
		else $error("fractional multiply wrong");
	a_pointer_call_op_push: assert property (take && OP == pointer_call_op
		|=> BUSY[*3] ##1 (PC_WE && PUSH_WE && PC_OUT == zp_r && !SREG_WE))
		else $error("pointer call wrong");
	a_skip_long: assert property (take && OP == compare_skip_equal_op
		&& DST_VAL == SRC_VAL && NEXT_LONG |=> BUSY[*3] ##1 (PC_WE && PC_OUT == 16'(pc_r + 16'h0003)))
		else $error("skip by three wrong");
	a_cpi_no_store: assert property (DONE && op_r == compare_immediate_op
		|-> !REG_WE && SREG_WE && SREG_OUT[`FLAG_Z] == (dst_r == imm_r))
		else $error("compare immediate wrong");
	a_no_skip_fast: assert property (take && (OP == skip_reg_bit_low_op ||
		OP == skip_io_bit_low_op) && (OP == skip_io_bit_low_op ? IO_VAL[BIT_SEL] : SRC_VAL[BIT_SEL])
		|=> BUSY ##1 (DONE && !PC_WE && !SREG_WE)) else $error("non skip timing wrong");
	a_call_four: assert property (take && OP == absolute_call_op && ABS_BRANCH_EN
		|=> BUSY[*4] ##1 (DONE && PC_WE && PUSH_WE))
		else $error("absolute call timing wrong");
	a_commit_together: assert property ((REG_WE || SREG_WE || PAIR_WE || PC_WE)
		|-> DONE && !BUSY)
		else $error("write outside completion");

endmodule

// file: exec_core_model.sv
`timescale 1ns/1ns
module exec_core_model
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Commit from the datapath
	input  wire logic        done,
	input  wire logic        sreg_we,
	input  wire logic [7:0]  sreg_out,
	input  wire logic        pc_we,
	input  wire logic [15:0] pc_out,
	// State seen by the next instruction
	output logic      [7:0]  sreg_r,
	output logic      [15:0] pc_r
);
	// ********************
	// Status register
	// ********************
	// Written only on the completion pulse, so a stale image shows up at once
	always_ff @(posedge clk)
	begin
		if (rst)
			sreg_r <= 8'h00;
		else if (done && sreg_we)
			sreg_r <= sreg_out;
	end

	// ********************
	// Program counter
	// ********************
	// Non-zero start so that pointer and skip targets differ from reset values
	always_ff @(posedge clk)
	begin
		if (rst)
			pc_r <= 16'h0100;
		else if (done)
			pc_r <= pc_we ? pc_out : pc_r + 16'h0001;
	end
endmodule

// file: mcu_arith_branch_exec_bench.sv
`timescale 1ns/1ns
module mcu_arith_branch_exec_bench;
	import exec_pkg::*;
	localparam logic [7:0] AR = 8'h2F;
	localparam logic [7:0] WD = 8'h1F;
	localparam logic [7:0] LG = 8'h0E;
	localparam logic [7:0] ML = 8'h03;
	logic        MCLK, RST, START, NEXT_LONG;
	op_t         OP;
	logic [7:0]  DST_VAL, DST_HI_VAL, SRC_VAL, IMM_VAL, IO_VAL, SREG_IN, RES_LO, RES_HI;
	logic [2:0]  BIT_SEL;
	logic [15:0] Z_PTR, TARGET, PC_IN, PC_OUT, PUSH_ADDR;
	logic [7:0]  SREG_OUT;
	logic        BUSY, DONE, REG_WE, PAIR_WE, PROD_WE, SREG_WE, PC_WE, PUSH_WE;
	int          num_errors, n_tests;

	mcu_arith_branch_exec i_dut
	(
		.MCLK(MCLK), .RST(RST), .START(START), .OP(OP), .DST_VAL(DST_VAL),
		.DST_HI_VAL(DST_HI_VAL), .SRC_VAL(SRC_VAL), .IMM_VAL(IMM_VAL),
		.BIT_SEL(BIT_SEL), .IO_VAL(IO_VAL), .SREG_IN(SREG_IN), .PC_IN(PC_IN),
		.Z_PTR(Z_PTR), .TARGET(TARGET), .NEXT_LONG(NEXT_LONG), .BUSY(BUSY),
		.DONE(DONE), .REG_WE(REG_WE), .PAIR_WE(PAIR_WE), .PROD_WE(PROD_WE),
		.RES_LO(RES_LO), .RES_HI(RES_HI), .SREG_WE(SREG_WE), .SREG_OUT(SREG_OUT),
		.PC_WE(PC_WE), .PC_OUT(PC_OUT), .PUSH_WE(PUSH_WE), .PUSH_ADDR(PUSH_ADDR)
	);

	exec_core_model i_core
	(
		.clk(MCLK), .rst(RST), .done(DONE), .sreg_we(SREG_WE), .sreg_out(SREG_OUT),
		.pc_we(PC_WE), .pc_out(PC_OUT), .sreg_r(SREG_IN), .pc_r(PC_IN)
	);

	initial
	begin
		MCLK = 1'b0;
		forever #20 MCLK = ~MCLK;
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic final_report;
		$display("Checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Holding START through a busy cycle must not start a second operation
	task automatic issue(input op_t op, input logic poke, input int lat);
		int n;
		n = 0;
		OP = op;
		START = 1'b1;
		@(posedge MCLK);
		#2;
		if (!poke)
			START = 1'b0;
		check("busy", 16'h0001, {15'h0000, BUSY});
		while (n < 8 && DONE !== 1'b1)
		begin
			@(posedge MCLK);
			#2;
			START = 1'b0;
			n++;
		end
		check("latency", lat[15:0], n[15:0]);
		if (n >= 8)
			final_report;
	endtask

	task automatic settle;
		@(posedge MCLK);
		#2;
		check("done low", 16'h0000, {15'h0000, DONE});
		check("busy low", 16'h0000, {15'h0000, BUSY});
	endtask

	task automatic alu(input op_t op, input logic [15:0] d, input logic [7:0] s, k,
		input int lat, input logic [2:0] we, input logic [15:0] res,
		input logic [7:0] mask, val, input logic poke);
		logic [7:0] old;
		old = SREG_IN;
		DST_VAL = d[7:0];
		DST_HI_VAL = d[15:8];
		SRC_VAL = s;
		IMM_VAL = k;
		issue(op, poke, lat);
		check("strobes", {13'h0000, we}, {13'h0000, PROD_WE, PAIR_WE, REG_WE});
		if (we != 3'b000)
			check("res lo", {8'h00, res[7:0]}, {8'h00, RES_LO});
		if (we[2:1] != 2'b00)
			check("res hi", {8'h00, res[15:8]}, {8'h00, RES_HI});
		check("flag we", {15'h0000, |mask}, {15'h0000, SREG_WE});
		check("flags", {8'h00, (old & ~mask) | val}, {8'h00, SREG_OUT});
		check("pc we", 16'h0000, {15'h0000, PC_WE});
		settle;
	endtask

	task automatic flow(input op_t op, input logic [7:0] d, s, io, input logic [2:0] b,
		input logic nl, input int lat, input logic jump, input logic [15:0] step,
		input logic push, input logic [15:0] ret);
		logic [15:0] pc, exp;
		pc = PC_IN;
		DST_VAL = d;
		SRC_VAL = s;
		IO_VAL = io;
		BIT_SEL = b;
		NEXT_LONG = nl;
		exp = pc + step;
		if (op == pointer_jump_op || op == pointer_call_op)
			exp = Z_PTR;
		if (op == absolute_jump_op || op == absolute_call_op)
			exp = TARGET;
		issue(op, 1'b0, lat);
		check("pc we", {15'h0000, jump}, {15'h0000, PC_WE});
		if (jump)
			check("pc", exp, PC_OUT);
		check("push we", {15'h0000, push}, {15'h0000, PUSH_WE});
		if (push)
			check("push addr", pc + ret, PUSH_ADDR);
		check("no writes", 16'h0000, {12'h000, SREG_WE, PROD_WE, PAIR_WE, REG_WE});
		settle;
	endtask

	initial
	begin
		num_errors = 0;
		n_tests = 0;
		RST = 1'b1;
		START = 1'b0;
		OP = nop_op;
		{DST_VAL, DST_HI_VAL, SRC_VAL, IMM_VAL, IO_VAL} = 40'h00_0000_0000;
		BIT_SEL = 3'h0;
		NEXT_LONG = 1'b0;
		Z_PTR = 16'h1234;
		TARGET = 16'h2345;
		repeat (4) @(posedge MCLK);
		#2;
		check("reset idle", 16'h0000, {14'h0000, BUSY, DONE});
		RST = 1'b0;
		@(posedge MCLK);
		#2;
		alu(add_op, 16'h007F, 8'h01, 8'h00, 1, 3'b001, 16'h0080, AR, 8'h2C, 0);
		alu(add_op, 16'h00FF, 8'h01, 8'h00, 1, 3'b001, 16'h0000, AR, 8'h23, 0);
		alu(add_carry_op, 16'h0010, 8'h20, 8'h00, 1, 3'b001, 16'h0031, AR, 8'h00, 0);
		alu(sub_op, 16'h0000, 8'h01, 8'h00, 1, 3'b001, 16'h00FF, AR, 8'h25, 0);
		alu(sub_carry_immediate_op,
			16'h0005, 8'h00, 8'h02, 1, 3'b001, 16'h0002, AR, 8'h00, 0);
		alu(sub_with_carry_op, 16'h0080, 8'h01, 8'h00, 1, 3'b001, 16'h007F, AR, 8'h28, 0);
		alu(and_op, 16'h00F0, 8'h3C, 8'h00, 1, 3'b001, 16'h0030, LG, 8'h00, 0);
		alu(and_immediate_op, 16'h0080, 8'h00, 8'hFF, 1, 3'b001, 16'h0080, LG, 8'h04, 0);
		alu(sub_immediate_op, 16'h0010, 8'h00, 8'h01, 1, 3'b001, 16'h000F, AR, 8'h20, 0);
		alu(word_add_immediate_op, 16'h7FFF, 8'h00, 8'h01, 2, 3'b010, 16'h8000, WD, 8'h0C, 1);
		alu(word_sub_immediate_op, 16'h0000, 8'h00, 8'h01, 2, 3'b010, 16'hFFFF, WD, 8'h15, 0);
		alu(or_op, 16'h0000, 8'h00, 8'h00, 1, 3'b001, 16'h0000, LG, 8'h02, 0);
		alu(or_immediate_op, 16'h0001, 8'h00, 8'h80, 1, 3'b001, 16'h0081, LG, 8'h04, 0);
		alu(set_bits_op, 16'h000F, 8'h00, 8'hF0, 1, 3'b001, 16'h00FF, LG, 8'h04, 0);
		alu(clear_bits_op, 16'h00FF, 8'h00, 8'h0F, 1, 3'b001, 16'h00F0, LG, 8'h04, 0);
		alu(test_value_op, 16'h0000, 8'h00, 8'h00, 1, 3'b001, 16'h0000, LG, 8'h02, 0);
		alu(compare_immediate_op, 16'h0003, 8'h00, 8'h05, 1, 3'b000, 16'h0000, AR, 8'h25, 0);
		alu(multiply_op, 16'h00FF, 8'hFF, 8'h00, 2, 3'b100, 16'hFE01, ML, 8'h01, 1);
		alu(multiply_op, 16'h0000, 8'h55, 8'h00, 2, 3'b100, 16'h0000, ML, 8'h02, 0);
		alu(signed_multiply_op, 16'h00FF, 8'hFF, 8'h00, 2, 3'b100, 16'h0001, ML, 8'h00, 0);
		alu(mixed_sign_multiply_op,
			16'h00FF, 8'h02, 8'h00, 2, 3'b100, 16'hFFFE, ML, 8'h01, 0);
		alu(fractional_multiply_op,
			16'h0080, 8'h80, 8'h00, 2, 3'b100, 16'h8000, ML, 8'h00, 0);
		alu(fractional_signed_multiply_op,
			16'h0080, 8'h80, 8'h00, 2, 3'b100, 16'h8000, ML, 8'h00, 0);
		alu(fractional_mixed_multiply_op,
			16'h00FF, 8'h02, 8'h00, 2, 3'b100, 16'hFFFC, ML, 8'h01, 0);
		flow(compare_skip_equal_op,
			8'h5A, 8'h5A, 8'h00, 3'h0, 0, 2, 1, 16'h0002, 0, 16'h0000);
		flow(compare_skip_equal_op,
			8'h5A, 8'h5A, 8'h00, 3'h0, 1, 3, 1, 16'h0003, 0, 16'h0000);
		flow(compare_skip_equal_op,
			8'h5A, 8'h5B, 8'h00, 3'h0, 1, 1, 0, 16'h0000, 0, 16'h0000);
		flow(skip_reg_bit_low_op, 8'h00, 8'hF7, 8'h00, 3'h3, 0, 2, 1, 16'h0002, 0, 16'h0000);
		flow(skip_reg_bit_low_op, 8'h00, 8'h08, 8'h00, 3'h3, 0, 1, 0, 16'h0000, 0, 16'h0000);
		flow(skip_io_bit_low_op, 8'h00, 8'h00, 8'h7F, 3'h7, 1, 3, 1, 16'h0003, 0, 16'h0000);
		flow(skip_io_bit_low_op, 8'h00, 8'h00, 8'h80, 3'h7, 1, 1, 0, 16'h0000, 0, 16'h0000);
		flow(pointer_jump_op, 8'h00, 8'h00, 8'h00, 3'h0, 0, 2, 1, 16'h0000, 0, 16'h0000);
		flow(pointer_call_op, 8'h00, 8'h00, 8'h00, 3'h0, 0, 3, 1, 16'h0000, 1, 16'h0001);
		flow(absolute_jump_op, 8'h00, 8'h00, 8'h00, 3'h0, 0, 3, 1, 16'h0000, 0, 16'h0000);
		flow(absolute_call_op, 8'h00, 8'h00, 8'h00, 3'h0, 0, 4, 1, 16'h0000, 1, 16'h0002);
		final_report;
	end
endmodule
